/* hdl/cmr_decode.sv */
// Instruction decoder for the move, OR and return execution block.
// Assumes a stable instruction word on the core clock.
`timescale 1ns/10ps
module cmr_decode
  import cmr_pkg::*;
(
  // Instruction
  input  wire logic [13:0] insn_i,
  // Decoded class
  output cmr_dec_t         dec_o
);

  // ------------------------------------------------------------------
  // Opcode matching
  // ------------------------------------------------------------------
  wire logic is_ior;
  wire logic is_move_file_value;
  wire logic is_stw;
  wire logic is_lit;
  wire logic is_rfi;
  wire logic is_nop;

  assign is_ior  = (insn_i & OP_IOR_MASK) == OP_IOR_VAL;
  assign is_move_file_value = (insn_i & OP_IOR_MASK) == OP_MOVE_FILE_VALUE_VAL;
  assign is_stw  = (insn_i & OP_STW_MASK) == OP_STW_VAL;
  // Unused literal bits are assumed zero by the assembler.
  assign is_lit  = (insn_i & OP_LIT_MASK) == OP_LIT_VAL;
  assign is_rfi  = (insn_i & OP_FULL_MASK) == OP_RFI_VAL;
  assign is_nop  = (insn_i & OP_NOP_MASK) == OP_NOP_VAL;

  assign dec_o.or_accum_with_file  = is_ior;
  assign dec_o.move_file_value     = is_move_file_value;
  assign dec_o.store_accum_to_file = is_stw;
  assign dec_o.load_literal_accum  = is_lit;
  assign dec_o.no_operation        = is_nop;
  assign dec_o.return_from_irq     = is_rfi;

endmodule : cmr_decode

/* hdl/cmr_exec.sv */
// Execution unit for OR, moves, literal load, no-op and interrupt return.
// Assumes the file register read data is valid in the cycle it is
// addressed, and that the stack top is presented on stack_top_entry_i.
// Assumes the instruction source holds insn_i steady while
// insn_valid_i is high, and that the register file and the interrupt
// control register take their strobes in the cycle they are raised.
`timescale 1ns/10ps
module cmr_exec
  import cmr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Instruction stream
  input  wire logic [13:0] insn_i,
  input  wire logic        insn_valid_i,
  output logic             insn_ready_o,
  // File register read port
  output logic [6:0]       file_raddr_o,
  input  wire logic [7:0]  file_rdata_i,
  // File register write port
  output logic [6:0]       file_waddr_o,
  output logic [7:0]       file_wdata_o,
  output logic             file_we_o,
  // Hardware stack
  input  wire logic [12:0] stack_top_entry_i,
  output logic             stack_pop_o,
  // Interrupt control register, global enable set strobe
  output logic             global_irq_enable_set_o,
  // Core state
  output logic [7:0]       accum_o,
  output logic             zero_flag_o,
  output logic [12:0]      program_counter_o
);

  // ------------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RFI = 2'b10
  } cmr_state_t;

  cmr_state_t  state_q;
  cmr_state_t  state_d;
  cmr_dec_t    dec;
  logic [7:0]  accum_q;
  logic [7:0]  accum_d;
  logic        zero_q;
  logic        zero_d;
  logic [12:0] pc_q;
  logic [12:0] pc_d;

  cmr_decode cmr_decode_inst (
    .insn_i (insn_i),
    .dec_o  (dec)
  );

  // ------------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------------
  wire logic       run_go;
  wire logic       dest_file;
  wire logic [7:0] or_result;
  wire logic [7:0] alu_result;
  wire logic       alu_zero;
  wire logic       uses_alu;
  wire logic       rfi_start;

  assign run_go     = (state_q == ST_RUN) && insn_valid_i;
  assign dest_file  = insn_i[DEST_BIT];
  assign or_result  = accum_q | file_rdata_i;
  // Move-file passes the file value straight through.
  assign alu_result = dec.or_accum_with_file ? or_result : file_rdata_i;
  assign alu_zero   = (alu_result == 8'h00);
  assign uses_alu   = dec.or_accum_with_file | dec.move_file_value;
  assign rfi_start  = run_go && dec.return_from_irq;

  // ------------------------------------------------------------------
  // File register ports
  // ------------------------------------------------------------------
  // The write side travels as one carrier so that address, data and
  // strobe cannot drift apart. The carrier address is one bit wider than
  // the file address in the instruction; its top bit is always zero.
  cmr_file_wr_t file_wr;

  assign file_raddr_o = insn_i[FADDR_W-1:0];
  assign file_wr.addr = {1'b0, insn_i[FADDR_W-1:0]};
  // Write back to file on d = 1 for OR and move-file, or for the store instruction.
  assign file_wr.we   = run_go
                        && ((uses_alu && dest_file)
                            || dec.store_accum_to_file);
  assign file_wr.data = dec.store_accum_to_file ? accum_q : alu_result;

  assign file_waddr_o = file_wr.addr[FADDR_W-1:0];
  assign file_wdata_o = file_wr.data;
  assign file_we_o    = file_wr.we;

  // ------------------------------------------------------------------
  // Handshake and return strobes
  // ------------------------------------------------------------------
  // The instruction is held until the return has used its second cycle.
  assign insn_ready_o = ((state_q == ST_RUN) && !dec.return_from_irq)
                        || (state_q == ST_RFI);

  // Pop and enable happen together in the second cycle of the return.
  // Both come straight from the state register, so they are one-cycle
  // pulses that cannot repeat while the same return word is held.
  assign stack_pop_o             = (state_q == ST_RFI);
  assign global_irq_enable_set_o = (state_q == ST_RFI);

  // ------------------------------------------------------------------
  // Next-value selection
  // ------------------------------------------------------------------
  wire logic        acc_from_alu;
  wire logic        acc_from_lit;
  wire logic        zero_from_alu;
  wire logic        pc_advance;
  wire logic        pc_from_stack;
  wire logic [7:0]  literal_value;
  wire logic [12:0] pc_next_seq;

  // No-op and store fall through to just the increment.
  assign acc_from_alu  = run_go && uses_alu && !dest_file;
  assign acc_from_lit  = run_go && dec.load_literal_accum;
  assign zero_from_alu = run_go && uses_alu;
  assign pc_advance    = run_go && !dec.return_from_irq;
  assign pc_from_stack = (state_q == ST_RFI);
  assign literal_value = insn_i[DATA_W-1:0];
  assign pc_next_seq   = pc_q + 13'h0001;

  // Literal load and ALU write to the accumulator never share a word.
  assign accum_d = acc_from_lit ? literal_value
                   : acc_from_alu ? alu_result
                   : accum_q;
  // Store, literal load, no-op and return leave the zero flag alone.
  assign zero_d  = zero_from_alu ? alu_zero : zero_q;
  // A return takes its address from the stack, never from the increment.
  assign pc_d    = pc_from_stack ? stack_top_entry_i
                   : pc_advance ? pc_next_seq
                   : pc_q;

  // ------------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------------
  // A return waits one cycle in ST_RFI; every other word stays in ST_RUN.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: begin
        if (rfi_start) begin
          state_d = ST_RFI;
        end
      end
      ST_RFI: begin
        // Flags are not touched during the return.
        state_d = ST_RUN;
      end
      default: begin
        // An illegal code goes back to running rather than locking up.
        state_d = ST_RUN;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // One register per block keeps each reset value next to its use.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      accum_q <= ACCUM_RST;
    end else begin
      accum_q <= accum_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zero_q <= ZERO_RST;
    end else begin
      zero_q <= zero_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_q <= PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ------------------------------------------------------------------
  // Core state outputs
  // ------------------------------------------------------------------
  assign accum_o           = accum_q;
  assign zero_flag_o       = zero_q;
  assign program_counter_o = pc_q;

endmodule : cmr_exec

/* hdl/cmr_pkg.sv */
// Package for the move, OR and return execution block of the core.
// Assumes a 14-bit instruction word and 13-bit program counter.
package cmr_pkg;

  // ------------------------------------------------------------------
  // Instruction word layout
  // ------------------------------------------------------------------
  localparam int INSN_W       = 14;
  localparam int FADDR_W      = 7;
  localparam int DATA_W       = 8;
  localparam int PC_W         = 13;
  localparam int DEST_BIT     = 7;
  localparam int GIE_BIT      = 7;

  // Opcode patterns: fixed bits and masks.
  localparam logic [13:0] OP_IOR_MASK  = 14'h3f00;
  localparam logic [13:0] OP_IOR_VAL   = 14'h0400;
  localparam logic [13:0] OP_MOVE_FILE_VALUE_VAL  = 14'h0800;
  localparam logic [13:0] OP_STW_MASK  = 14'h3f80;
  localparam logic [13:0] OP_STW_VAL   = 14'h0080;
  localparam logic [13:0] OP_LIT_MASK  = 14'h3c00;
  localparam logic [13:0] OP_LIT_VAL   = 14'h3000;
  localparam logic [13:0] OP_NOP_MASK  = 14'h3f9f;
  localparam logic [13:0] OP_NOP_VAL   = 14'h0000;
  localparam logic [13:0] OP_RFI_VAL   = 14'h0009;
  localparam logic [13:0] OP_FULL_MASK = 14'h3fff;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  ACCUM_RST    = 8'h00;
  localparam logic [12:0] PC_RST       = 13'h0000;
  localparam logic        ZERO_RST     = 1'b0;

  // Cycles taken by the return-from-interrupt instruction.
  localparam int RFI_CYCLES            = 2;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       we;
  } cmr_file_wr_t;

  typedef struct packed {
    logic or_accum_with_file;
    logic move_file_value;
    logic store_accum_to_file;
    logic load_literal_accum;
    logic no_operation;
    logic return_from_irq;
  } cmr_dec_t;

endpackage : cmr_pkg

/* verification/cmr_exec_properties.sv */
// Port checks for the execution unit.
// Assumes a bind into cmr_exec on its one core clock.
`timescale 1ns/10ps
module cmr_exec_properties
  import cmr_pkg::*;
(
  // Inputs and results
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [13:0] insn_i,
  input wire logic        insn_valid_i,
  input wire logic        insn_ready_o,
  input wire logic [7:0]  file_rdata_i,
  input wire logic [7:0]  file_wdata_o,
  input wire logic        file_we_o,
  input wire logic [12:0] stack_top_entry_i,
  input wire logic        stack_pop_o,
  input wire logic        global_irq_enable_set_o,
  input wire logic [7:0]  accum_o,
  input wire logic        zero_flag_o,
  input wire logic [12:0] program_counter_o
);
  wire tk = insn_valid_i & insn_ready_o;
  wire df = insn_i[DEST_BIT];
  wire is_or = (insn_i & OP_IOR_MASK) == OP_IOR_VAL;
  wire is_mv = (insn_i & OP_IOR_MASK) == OP_MOVE_FILE_VALUE_VAL;
  wire is_st = (insn_i & OP_STW_MASK) == OP_STW_VAL;
  wire is_lt = (insn_i & OP_LIT_MASK) == OP_LIT_VAL;
  wire is_np = (insn_i & OP_NOP_MASK) == OP_NOP_VAL;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_or_accum: assert property (tk && is_or && !df |=>
    accum_o == ($past(accum_o) | $past(file_rdata_i))) else $error("or");
  a_or_zero: assert property (tk && is_or |=>
    zero_flag_o == (($past(accum_o) | $past(file_rdata_i)) == 8'h00))
    else $error("or z");
  a_or_file: assert property (tk && is_or && df |-> file_we_o &&
    file_wdata_o == (accum_o | file_rdata_i)) else $error("or wr");
  a_move_accum: assert property (tk && is_mv && !df |=>
    accum_o == $past(file_rdata_i)) else $error("mv acc");
  a_move_zero: assert property (tk && is_mv |=>
    zero_flag_o == ($past(file_rdata_i) == 8'h00)) else $error("mv z");
  a_store_write: assert property (tk && is_st |-> file_we_o &&
    file_wdata_o == accum_o ##1 $stable(zero_flag_o)) else $error("st");
  a_literal_load: assert property (tk && is_lt |=>
    accum_o == 8'($past(insn_i)) && $stable(zero_flag_o)) else $error("lt");
  a_nop_state: assert property (tk && is_np |=> $stable(accum_o) &&
    program_counter_o == $past(program_counter_o) + 13'h1) else $error("np");
  a_return_pop: assert property (insn_valid_i && insn_i == OP_RFI_VAL &&
    !insn_ready_o |=> stack_pop_o && global_irq_enable_set_o)
    else $error("rfi pop");
  a_return_pc: assert property (stack_pop_o |=>
    program_counter_o == $past(stack_top_entry_i)) else $error("rfi pc");
  a_pop_single: assert property (stack_pop_o |=> !stack_pop_o)
    else $error("pop");
  a_return_flags: assert property (stack_pop_o |=>
    $stable(zero_flag_o) && $stable(accum_o)) else $error("rfi flags");
endmodule : cmr_exec_properties

/* verification/cpu_move_or_return_ops_test.sv */
// Bench for the execution unit.
// Assumes the bench alone feeds instructions, file data and stack top.
`timescale 1ns/10ps
module cpu_move_or_return_ops_test;
  import cmr_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [13:0] insn_i = 14'h0000;
  logic        vld = 1'b0;
  logic [7:0]  rdat = 8'h00;
  logic [12:0] stack_top_entry = 13'h0000;
  logic [6:0]  raddr, waddr;
  logic [7:0]  wdata, accum, wd_s;
  logic        ready, we, pop, global_irq_enable, zero, we_s, pop_s, gie_s;
  logic [12:0] pc, pc_x;
  int          num_errors = 0;
  int          checked = 0;
  int          waits = 0;
  always #2 clk_i = ~clk_i;
  cmr_exec cmr_exec_inst (.clk_i(clk_i), .rst_i(rst_i), .insn_i(insn_i),
    .insn_valid_i(vld), .insn_ready_o(ready), .file_raddr_o(raddr),
    .file_rdata_i(rdat), .file_waddr_o(waddr), .file_wdata_o(wdata),
    .file_we_o(we), .stack_top_entry_i(stack_top_entry), .stack_pop_o(pop),
    .global_irq_enable_set_o(global_irq_enable), .accum_o(accum), .zero_flag_o(zero),
    .program_counter_o(pc));
  task chk(input string nm, input logic [12:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Return holds ready low one cycle, so the wait is bounded, not fixed.
  task step(input logic [13:0] ins, input logic [7:0] rd);
    int n;
    n = 0;
    @(negedge clk_i);
    insn_i = ins;
    vld = 1'b1;
    rdat = rd;
    #1;
    while (ready !== 1'b1) begin
      n++;
      if (n > 4) begin
        num_errors++;
        finish_test();
      end
      @(negedge clk_i);
      #1;
    end
    {we_s, wd_s, pop_s, gie_s} = {we, wdata, pop, global_irq_enable};
    waits = n;
    chk("raddr", 13'(raddr), 13'(ins[6:0]));
    chk("waddr", 13'(waddr), 13'(ins[6:0]));
    @(negedge clk_i);
    vld = 1'b0;
    pc_x = pop_s ? stack_top_entry : pc_x + 13'h1;
  endtask : step
  task state(input logic [7:0] a, input logic z);
    chk("accum", 13'(accum), 13'(a));
    chk("zero", 13'(zero), 13'(z));
    chk("pc", pc, pc_x);
  endtask : state
  task or_test;
    step(14'h303c, 8'h00);
    step(14'h0405, 8'h41);
    state(8'h7d, 1'b0);
    step(14'h0485, 8'h02);
    chk("or_wr", {4'h0, we_s, wd_s}, 13'h17f);
    state(8'h7d, 1'b0);
    step(14'h3000, 8'h00);
    step(14'h0407, 8'h00);
    state(8'h00, 1'b1);
  endtask : or_test
  task move_store_test;
    step(14'h0811, 8'ha5);
    state(8'ha5, 1'b0);
    step(14'h0891, 8'h00);
    chk("mv_wr", {4'h0, we_s, wd_s}, 13'h100);
    state(8'ha5, 1'b1);
    step(14'h00d2, 8'h33);
    chk("st_wr", {4'h0, we_s, wd_s}, 13'h1a5);
    chk("st_wait", 13'(waits), 13'h0);
    state(8'ha5, 1'b1);
  endtask : move_store_test
  task lit_nop_return_test;
    step(14'h30ff, 8'h00);
    state(8'hff, 1'b1);
    step(14'h0000, 8'h00);
    chk("nop_strb", {10'h0, we_s, pop_s, gie_s}, 13'h0);
    state(8'hff, 1'b1);
    stack_top_entry = 13'h1abc;
    step(OP_RFI_VAL, 8'h00);
    chk("pop_gie", {11'h0, pop_s, gie_s}, 13'h3);
    chk("rfi_wait", 13'(waits), 13'(RFI_CYCLES - 1));
    state(8'hff, 1'b1);
    step(14'h0000, 8'h00);
    state(8'hff, 1'b1);
  endtask : lit_nop_return_test
  // A mid-run reset must bring back the starting state and let work resume.
  task reset_test;
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    pc_x = PC_RST;
    chk("rst_strb", {11'h0, pop, global_irq_enable}, 13'h0);
    state(ACCUM_RST, ZERO_RST);
    rst_i = 1'b0;
    step(14'h0405, 8'h41);
    state(8'h41, 1'b0);
  endtask : reset_test
  initial begin
    pc_x = PC_RST;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    state(ACCUM_RST, ZERO_RST);
    or_test();
    move_store_test();
    lit_nop_return_test();
    reset_test();
    finish_test();
  end
endmodule : cpu_move_or_return_ops_test
bind cmr_exec cmr_exec_properties cmr_exec_properties_inst (.clk_i(clk_i),
  .rst_i(rst_i), .insn_i(insn_i), .insn_valid_i(insn_valid_i),
  .insn_ready_o(insn_ready_o), .file_rdata_i(file_rdata_i),
  .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
  .stack_top_entry_i(stack_top_entry_i), .stack_pop_o(stack_pop_o),
  .global_irq_enable_set_o(global_irq_enable_set_o), .accum_o(accum_o),
  .zero_flag_o(zero_flag_o), .program_counter_o(program_counter_o));
